// ==== rtl/pwg_map.svh ====
`ifndef PWG_MAP_SVH
`define PWG_MAP_SVH
// register byte offsets
`define PWG_ENABLE_OFS    8'h00
`define PWG_INVERT_OFS    8'h04
`define PWG_CLKCFG_OFS    8'h08
`define PWG_MODE_OFS      8'h0C
`define PWG_GROUP_OFS     8'h10
`define PWG_TRIG_OFS      8'h14
`define PWG_ALT_OFS       8'h18
`define PWG_QUEUE_OFS     8'h1C
`define PWG_FLAGS_OFS     8'h20
`define PWG_LEVEL_OFS     8'h24
`define PWG_TIMING_OFS    8'h40
// mode codes
`define PWG_MODE_NORMAL   8'h00
`define PWG_MODE_COUNT    8'h01
`define PWG_MODE_IR       8'h03
`define PWG_MODE_QUEUE    8'h07
`define PWG_MODE_DMAQ     8'h0F
// descriptor fields
`define PWG_DESC_CARRIER  15
`define PWG_DESC_ALT      14
// flag bit positions
`define PWG_FLAG_GROUP    6
`define PWG_FLAG_QLOW     7
`define PWG_FLAG_DMADONE  8
`endif

// ==== rtl/pwg_pkg.sv ====
package pwg_pkg;
  typedef enum logic [1:0] {
    PWG_ST_IDLE,
    PWG_ST_RUN,
    PWG_ST_LOAD
  } pwg_state_e;
  typedef struct packed {
    logic [15:0] period;
    logic [15:0] compare;
  } pwg_timing_s;
  typedef struct packed {
    logic        carrier;
    logic        use_alt;
    logic [13:0] frames;
  } pwg_desc_s;
endpackage

// ==== rtl/pwg_top.sv ====
`timescale 1ns/1ps
`include "pwg_map.svh"
// Behaviour
// - complement output is inverse of waveform
// - high part first, low part after
// - channel 0 has alternate period/compare set
// - separate inversion for primary and complement
// - per channel enable starts and stops
// - channel 0 mode code selects behaviour
// - other channels only run continuously
// - frame count per group except normal
// - each channel flags every finished frame
// - channel 0 flags every finished group
// - queue low flag while depth below trigger
// - dma queue done flag after last entry
// - flags stay until software clears them
// - dma descriptors are two bytes each
// - segments play back to back in order
// - bit 15 carrier on, else low
// - bit 14 selects alternate timing set
// - segment plays exactly its frame count
// - tick from divider or slow clock
// - period zero halts, compare bounds output
module pwg_top #(
  parameter int NCH   = 6,  // channel count
  parameter int DEPTH = 8,  // queue entries
  parameter int AW    = 3   // queue index width
) (
  input  wire logic        aclk,          // 10 MHz clock
  input  wire logic        aresetn,       // sync reset, active low
  input  wire logic        slow_clk,      // 32 kHz clock pin
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // byte enables
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic [15:0] dma_data,      // dma descriptor word
  input  wire logic        dma_valid,     // dma word offered
  output logic             dma_ready,     // queue can take word
  input  wire logic        dma_last,      // final word of transfer
  output logic [NCH-1:0]   pwm_out,       // primary outputs
  output logic [NCH-1:0]   pwm_out_n      // complement outputs
);
  // ---------------- bus slave state ----------------
  logic        aw_hold_reg, aw_hold_next;   // address latched
  logic        w_hold_reg, w_hold_next;     // data latched
  logic [7:0]  awa_reg, awa_next;           // latched address
  logic [31:0] wd_reg, wd_next;             // latched data
  logic [3:0]  ws_reg, ws_next;             // latched strobes
  logic        bv_reg, bv_next;             // write response pending
  logic [1:0]  br_reg, br_next;             // write response code
  logic        rv_reg, rv_next;             // read data pending
  logic [31:0] rd_reg, rd_next;             // read data
  logic [1:0]  rr_reg, rr_next;             // read response code
  // ---------------- configuration ----------------
  logic [NCH-1:0] en_reg, en_next;          // channel enables
  logic [NCH-1:0] inv_reg, inv_next;        // primary inversion
  logic [NCH-1:0] ninv_reg, ninv_next;      // complement inversion
  logic [NCH-1:0] slow_reg, slow_next;      // per channel slow clock select
  logic [7:0]  div_reg, div_next;           // divider setting
  logic [7:0]  mode_reg, mode_next;         // channel 0 mode code
  logic [15:0] group_reg, group_next;       // frames per group
  logic [7:0]  trig_reg, trig_next;         // queue low trigger
  pwg_pkg::pwg_timing_s alt_reg, alt_next;  // alternate timing set
  logic [16:0] altp_reg, altp_next;         // alternate period, 1..65536
  pwg_pkg::pwg_timing_s tim_reg [NCH];      // main timing sets
  pwg_pkg::pwg_timing_s tim_next [NCH];
  logic [8:0]  flg_reg, flg_next;           // sticky flags
  // ---------------- queue ----------------
  logic [15:0] q_mem_reg [DEPTH];           // descriptor storage
  logic [15:0] q_mem_next [DEPTH];
  logic [AW-1:0] q_wp_reg, q_wp_next;       // write index
  logic [AW-1:0] q_rp_reg, q_rp_next;       // read index
  logic [AW:0] q_cnt_reg, q_cnt_next;       // stored entries
  logic        dlast_reg, dlast_next;       // last dma word queued
  logic        dma_rdy_reg, dma_rdy_next;   // registered dma ready
  // ---------------- tick and channel state ----------------
  logic [7:0]  pre_reg, pre_next;           // prescaler
  logic        s1_reg, s2_reg, s3_reg;      // slow clock synchroniser and edge
  logic [16:0] cnt_reg [NCH];               // frame counters
  logic [16:0] cnt_next [NCH];
  logic [NCH-1:0] wave_reg, wave_next;      // raw waveform
  logic [NCH-1:0] po_reg, po_next;          // primary pins
  logic [NCH-1:0] pn_reg, pn_next;          // complement pins
  logic [NCH-1:0] fdone;                    // frame completes this cycle
  pwg_pkg::pwg_state_e st_reg, st_next;     // channel 0 sequencer
  logic [15:0] left_reg, left_next;         // frames left in segment/group
  pwg_pkg::pwg_desc_s seg_reg, seg_next;    // active segment
  logic        gdone, segdone, take_q;      // channel 0 events
  logic        fast_tick, slow_tick;        // tick sources
  logic        wr_fire, q_push_sw, q_push_dma;
  logic [7:0]  wa;
  logic [31:0] wm;                          // byte enable mask

  assign s_axi_awready = ~aw_hold_reg;
  assign s_axi_wready  = ~w_hold_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = ~rv_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign dma_ready     = dma_rdy_reg;
  assign pwm_out       = po_reg;
  assign pwm_out_n     = pn_reg;

  // write happens once both halves are held and no response waits
  assign wr_fire = aw_hold_reg & w_hold_reg & ~bv_reg;
  assign wa      = awa_reg;
  assign wm      = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
  assign q_push_sw  = wr_fire && wa == `PWG_QUEUE_OFS && q_cnt_reg != DEPTH[AW:0]
                      && mode_reg == `PWG_MODE_QUEUE;
  assign q_push_dma = dma_valid & dma_rdy_reg;

  // divided tick: divider value plus one clock cycles per tick
  assign fast_tick = (pre_reg == div_reg);
  assign slow_tick = s2_reg & ~s3_reg;

  // pop on a load, and when a running segment ends with entries waiting
  assign take_q = en_reg[0] && q_cnt_reg != '0 && (st_reg == pwg_pkg::PWG_ST_LOAD || (segdone
                  && (mode_reg == `PWG_MODE_QUEUE || mode_reg == `PWG_MODE_DMAQ)));

  // channel 0 segment bookkeeping
  assign segdone = fdone[0] && left_reg == 16'h0001;
  assign gdone   = segdone && (mode_reg == `PWG_MODE_COUNT || mode_reg == `PWG_MODE_IR
                   || mode_reg == `PWG_MODE_QUEUE || mode_reg == `PWG_MODE_DMAQ);

  // bus slave and configuration next state
  always_comb begin
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    awa_next = awa_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    rv_next  = rv_reg;
    rd_next  = rd_reg;
    rr_next  = rr_reg;
    en_next  = en_reg;
    inv_next = inv_reg;
    ninv_next = ninv_reg;
    slow_next = slow_reg;
    div_next  = div_reg;
    mode_next = mode_reg;
    group_next = group_reg;
    trig_next  = trig_reg;
    alt_next   = alt_reg;
    altp_next  = altp_reg;
    for (int i = 0; i < NCH; i++) tim_next[i] = tim_reg[i];
    flg_next = flg_reg;
    // address and data taken in either order
    if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (bv_reg && s_axi_bready) bv_next = 1'b0;
    if (wr_fire) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bv_next = 1'b1;
      br_next = 2'b00;
      if (wa >= `PWG_TIMING_OFS && wa < `PWG_TIMING_OFS + 8'(4 * NCH) && wa[1:0] == 2'b00) begin
        // timing word: period high half, compare low half
        tim_next[3'(wa[4:2])] = (tim_reg[3'(wa[4:2])] & ~wm) | (wd_reg & wm);
      end else begin
        unique case (wa)
          `PWG_ENABLE_OFS: en_next = (en_reg & ~wm[NCH-1:0]) | (wd_reg[NCH-1:0] & wm[NCH-1:0]);
          `PWG_INVERT_OFS: begin
            inv_next  = wd_reg[NCH-1:0];
            ninv_next = wd_reg[8+NCH-1:8];
          end
          `PWG_CLKCFG_OFS: begin
            div_next  = wd_reg[7:0];
            slow_next = wd_reg[8+NCH-1:8];
          end
          `PWG_MODE_OFS:  mode_next  = wd_reg[7:0];
          `PWG_GROUP_OFS: group_next = wd_reg[15:0];
          `PWG_TRIG_OFS:  trig_next  = wd_reg[7:0];
          `PWG_ALT_OFS: begin
            // period field holds count minus one, so 1..65536 fits
            alt_next.compare = wd_reg[15:0];
            altp_next = {1'b0, wd_reg[31:16]} + 17'h00001;
          end
          `PWG_QUEUE_OFS: ;
          `PWG_FLAGS_OFS: flg_next = flg_reg & ~wd_reg[8:0];
          default: br_next = 2'b10;
        endcase
      end
    end
    // hardware sets win over a same-cycle clear
    for (int i = 0; i < NCH; i++) if (fdone[i]) flg_next[i] = 1'b1;
    if (gdone) flg_next[`PWG_FLAG_GROUP] = 1'b1;
    // counting and carrier modes stop once the group is out
    if (segdone && (mode_reg == `PWG_MODE_COUNT || mode_reg == `PWG_MODE_IR))
      en_next[0] = 1'b0;
    if (mode_reg == `PWG_MODE_QUEUE && {4'h0, q_cnt_reg} < trig_reg)
      flg_next[`PWG_FLAG_QLOW] = 1'b1;
    if (mode_reg == `PWG_MODE_DMAQ && segdone && dlast_reg && q_cnt_reg == '0)
      flg_next[`PWG_FLAG_DMADONE] = 1'b1;
    // read side
    if (rv_reg && s_axi_rready) rv_next = 1'b0;
    if (s_axi_arvalid && !rv_reg) begin
      rv_next = 1'b1;
      rr_next = 2'b00;
      rd_next = 32'h0000_0000;
      if (s_axi_araddr >= `PWG_TIMING_OFS && s_axi_araddr < `PWG_TIMING_OFS + 8'(4 * NCH)
          && s_axi_araddr[1:0] == 2'b00) begin
        rd_next = tim_reg[3'(s_axi_araddr[4:2])];
      end else begin
        unique case (s_axi_araddr)
          `PWG_ENABLE_OFS: rd_next[NCH-1:0] = en_reg;
          `PWG_INVERT_OFS: rd_next = {16'h0000, 2'b00, ninv_reg, 2'b00, inv_reg};
          `PWG_CLKCFG_OFS: rd_next = {16'h0000, 2'b00, slow_reg, div_reg};
          `PWG_MODE_OFS:   rd_next[7:0] = mode_reg;
          `PWG_GROUP_OFS:  rd_next[15:0] = group_reg;
          `PWG_TRIG_OFS:   rd_next[7:0] = trig_reg;
          `PWG_ALT_OFS:    rd_next = {altp_reg[15:0] - 16'h0001, alt_reg.compare};
          `PWG_QUEUE_OFS:  rd_next = 32'h0000_0000;
          `PWG_FLAGS_OFS:  rd_next[8:0] = flg_reg;
          `PWG_LEVEL_OFS:  rd_next = {14'h0000, st_reg, 12'h000, 4'(q_cnt_reg)};
          default:         rr_next = 2'b10;
        endcase
      end
    end
  end

  // queue next state: software writes or dma words, sequencer pops
  always_comb begin
    for (int i = 0; i < DEPTH; i++) q_mem_next[i] = q_mem_reg[i];
    q_wp_next = q_wp_reg;
    q_rp_next = q_rp_reg;
    q_cnt_next = q_cnt_reg;
    dlast_next = dlast_reg;
    if (q_push_sw) begin
      q_mem_next[q_wp_reg] = wd_reg[15:0];
      q_wp_next = q_wp_reg + 1'b1;
    end else if (q_push_dma) begin
      q_mem_next[q_wp_reg] = dma_data;
      q_wp_next = q_wp_reg + 1'b1;
      dlast_next = dma_last;
    end
    if (take_q) q_rp_next = q_rp_reg + 1'b1;
    q_cnt_next = q_cnt_reg + (AW+1)'(q_push_sw | q_push_dma) - (AW+1)'(take_q);
    // leaving queued modes discards pending entries
    if (mode_reg != `PWG_MODE_QUEUE && mode_reg != `PWG_MODE_DMAQ) begin
      q_wp_next = '0;
      q_rp_next = '0;
      q_cnt_next = '0;
      dlast_next = 1'b0;
    end
    // ready only with space left once this cycle settles
    dma_rdy_next = mode_reg == `PWG_MODE_DMAQ && q_cnt_next < (AW+1)'(DEPTH - 1);
  end

  // channel 0 sequencer: segments and groups
  always_comb begin
    st_next = st_reg;
    left_next = left_reg;
    seg_next = seg_reg;
    unique case (st_reg)
      pwg_pkg::PWG_ST_IDLE: if (en_reg[0]) begin
        if (mode_reg == `PWG_MODE_QUEUE || mode_reg == `PWG_MODE_DMAQ) begin
          st_next = pwg_pkg::PWG_ST_LOAD;
        end else begin
          st_next = pwg_pkg::PWG_ST_RUN;
          seg_next = '{carrier: 1'b1, use_alt: 1'b0, frames: 14'h0000};
          left_next = group_reg;
        end
      end
      pwg_pkg::PWG_ST_LOAD: if (take_q) begin
        seg_next = q_mem_reg[q_rp_reg];
        left_next = {2'b00, q_mem_reg[q_rp_reg][13:0]};
        st_next = pwg_pkg::PWG_ST_RUN;
      end
      pwg_pkg::PWG_ST_RUN: begin
        if (fdone[0] && mode_reg != `PWG_MODE_NORMAL) left_next = left_reg - 16'h0001;
        if (segdone && mode_reg != `PWG_MODE_NORMAL) begin
          // queued modes fetch the next segment without a gap
          if ((mode_reg == `PWG_MODE_QUEUE || mode_reg == `PWG_MODE_DMAQ)
              && q_cnt_reg != '0) begin
            seg_next = q_mem_reg[q_rp_reg];
            left_next = {2'b00, q_mem_reg[q_rp_reg][13:0]};
          end else if (mode_reg == `PWG_MODE_QUEUE || mode_reg == `PWG_MODE_DMAQ) begin
            st_next = pwg_pkg::PWG_ST_LOAD;
          end else begin
            st_next = pwg_pkg::PWG_ST_IDLE;
          end
        end
      end
      default: st_next = pwg_pkg::PWG_ST_IDLE;
    endcase
    if (!en_reg[0]) st_next = pwg_pkg::PWG_ST_IDLE;
  end

  // per channel counters and pin logic
  always_comb begin
    pre_next = fast_tick ? 8'h00 : pre_reg + 8'h01;
    for (int i = 0; i < NCH; i++) begin
      logic [16:0] per;
      logic [15:0] cmp;
      logic        tick, on;
      per = {1'b0, tim_reg[i].period};
      cmp = tim_reg[i].compare;
      on  = 1'b1;
      if (i == 0) begin
        if (seg_reg.use_alt) begin
          per = altp_reg;
          cmp = alt_reg.compare;
        end
        // channel 0 lights only while the sequencer runs a segment with carrier set
        on = seg_reg.carrier && st_reg == pwg_pkg::PWG_ST_RUN;
      end
      tick = slow_reg[i] ? slow_tick : fast_tick;
      cnt_next[i] = cnt_reg[i];
      wave_next[i] = wave_reg[i];
      fdone[i] = 1'b0;
      if (!en_reg[i] || per == '0 || (i == 0 && st_reg != pwg_pkg::PWG_ST_RUN)) begin
        cnt_next[i] = '0;
        wave_next[i] = 1'b0;
      end else if (tick) begin
        // a frame ends with the tick that shows its last slot
        fdone[i] = cnt_reg[i] + 17'h00001 >= per;
        cnt_next[i] = fdone[i] ? 17'h00000 : cnt_reg[i] + 17'h00001;
        // slot shown is the count before the step: high below compare
        wave_next[i] = on && {1'b0, cmp} > cnt_reg[i];
      end
      po_next[i] = wave_reg[i] ^ inv_reg[i];
      pn_next[i] = ~wave_reg[i] ^ ninv_reg[i];
    end
  end

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      bv_reg <= 1'b0;
      br_reg <= 2'b00;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      rr_reg <= 2'b00;
      en_reg <= '0;
      inv_reg <= '0;
      ninv_reg <= '0;
      slow_reg <= '0;
      div_reg <= 8'h00;
      mode_reg <= `PWG_MODE_NORMAL;
      group_reg <= 16'h0000;
      trig_reg <= 8'h00;
      alt_reg <= '0;
      altp_reg <= 17'h00001;
      for (int i = 0; i < NCH; i++) begin
        tim_reg[i] <= '0;
        cnt_reg[i] <= '0;
      end
      flg_reg <= 9'h000;
      for (int i = 0; i < DEPTH; i++) q_mem_reg[i] <= 16'h0000;
      q_wp_reg <= '0;
      q_rp_reg <= '0;
      q_cnt_reg <= '0;
      dlast_reg <= 1'b0;
      dma_rdy_reg <= 1'b0;
      pre_reg <= 8'h00;
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      wave_reg <= '0;
      po_reg <= '0;
      pn_reg <= '1;
      st_reg <= pwg_pkg::PWG_ST_IDLE;
      left_reg <= 16'h0000;
      seg_reg <= '0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      en_reg <= en_next;
      inv_reg <= inv_next;
      ninv_reg <= ninv_next;
      slow_reg <= slow_next;
      div_reg <= div_next;
      mode_reg <= mode_next;
      group_reg <= group_next;
      trig_reg <= trig_next;
      alt_reg <= alt_next;
      altp_reg <= altp_next;
      for (int i = 0; i < NCH; i++) begin
        tim_reg[i] <= tim_next[i];
        cnt_reg[i] <= cnt_next[i];
      end
      flg_reg <= flg_next;
      for (int i = 0; i < DEPTH; i++) q_mem_reg[i] <= q_mem_next[i];
      q_wp_reg <= q_wp_next;
      q_rp_reg <= q_rp_next;
      q_cnt_reg <= q_cnt_next;
      dlast_reg <= dlast_next;
      dma_rdy_reg <= dma_rdy_next;
      pre_reg <= pre_next;
      s1_reg <= slow_clk;   // synchroniser first stage
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      wave_reg <= wave_next;
      po_reg <= po_next;
      pn_reg <= pn_next;
      st_reg <= st_next;
      left_reg <= left_next;
      seg_reg <= seg_next;
    end
  end
endmodule // pwg_top

// ==== sim/pwg_properties.sv ====
`timescale 1ns/1ps
// bus handshake and reset checks, seen from the top ports only
module pwg_properties #(
  parameter int NCH = 6  // channel count
) (
  input wire logic           aclk,          // clock
  input wire logic           aresetn,       // sync reset, active low
  input wire logic           s_axi_awvalid, // write address valid
  input wire logic           s_axi_awready, // write address ready
  input wire logic           s_axi_wvalid,  // write data valid
  input wire logic           s_axi_wready,  // write data ready
  input wire logic           s_axi_bvalid,  // write response valid
  input wire logic           s_axi_bready,  // write response ready
  input wire logic           s_axi_arvalid, // read address valid
  input wire logic           s_axi_rvalid,  // read data valid
  input wire logic           s_axi_rready,  // read data ready
  input wire logic [31:0]    s_axi_rdata,   // read data
  input wire logic           dma_ready,     // queue takes a word
  input wire logic [NCH-1:0] pwm_out,       // primary outputs
  input wire logic [NCH-1:0] pwm_out_n      // complement outputs
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the bench offers address and data together, so both go at one edge
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_taken;
    s_axi_bvalid && s_axi_bready;
  endsequence
  a_write_answer: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn");
  a_bvalid_drop: assert property (b_taken |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read data missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  // reset is seen here, so these two must not be disabled by it
  a_reset_pins: assert property (disable iff (1'b0) !aresetn |=>
    pwm_out == '0 && pwm_out_n == '1) else $error("outputs not idle");
  a_reset_dma: assert property (disable iff (1'b0) !aresetn |=> !dma_ready)
    else $error("queue open in reset");
endmodule // pwg_properties

// ==== sim/pwg_ir_load.sv ====
`timescale 1ns/1ps
// emitter load on channel 0: counts lit cycles, pulses and bad complements
module pwg_ir_load (
  input  wire logic aclk,     // clock
  input  wire logic clr,      // zero the counters
  input  wire logic emit,     // primary drive
  input  wire logic emit_n,   // complement drive
  output int        high_cnt, // cycles lit
  output int        edge_cnt, // pulses started
  output int        bad_cnt   // complement equal to primary
);
  logic emit_d;  // last level, for edge detection
  // a load only watches; it never drives the block
  always @(posedge aclk) begin
    if (clr) begin
      high_cnt <= 0;
      edge_cnt <= 0;
      bad_cnt <= 0;
    end else begin
      high_cnt <= high_cnt + int'(emit === 1'b1);
      edge_cnt <= edge_cnt + int'(emit === 1'b1 && emit_d !== 1'b1);
      bad_cnt <= bad_cnt + int'(emit_n === emit);
    end
    emit_d <= emit;
  end
endmodule // pwg_ir_load

// ==== sim/pwg_top_bench.sv ====
`timescale 1ns/1ps
`include "pwg_map.svh"
module pwg_top_bench;
  logic aclk = 0, aresetn = 0, slow_clk = 0, clr = 1;  // clock, reset, load clear
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;     // bus addresses
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;          // bus data
  logic [3:0] s_axi_wstrb = 4'hF;                     // byte enables
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;               // responses
  logic [15:0] dma_data = 0;                          // descriptor word
  logic dma_valid = 0, dma_last = 0, dma_ready;       // descriptor handshake
  logic [5:0] pwm_out, pwm_out_n;                     // outputs
  logic [4:0] sdiv = 0;                               // slow clock divider
  logic [31:0] d;                                     // read value
  logic [1:0] r;                                      // read response
  int mismatches = 0, checks = 0, cyc = 0, hi, ed, bad;
  logic [7:0] modes [5] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F};  // every mode code
  pwg_top i_dut (.*);
  pwg_ir_load i_load (.aclk(aclk), .clr(clr), .emit(pwm_out[0]), .emit_n(pwm_out_n[0]),
    .high_cnt(hi), .edge_cnt(ed), .bad_cnt(bad));
  always #50 aclk = ~aclk;
  // slow tick source, far slower than the main clock
  always @(posedge aclk) begin
    sdiv <= sdiv + 5'h01;
    slow_clk <= sdiv[4];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic dma_put(input logic [15:0] w, input logic l);
    @(posedge aclk);
    dma_data <= w;
    dma_last <= l;
    dma_valid <= 1'b1;
    do @(posedge aclk); while (dma_ready !== 1'b1);
    dma_valid <= 1'b0;
  endtask
  task automatic wait_flag(input int b);
    do rd(`PWG_FLAGS_OFS, d, r); while (d[b] !== 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1 chk(pwm_out, 32'h0);
    chk(pwm_out_n, 32'h3F);
    rd(`PWG_FLAGS_OFS, d, r);
    chk(d, 32'h0);
    rd(8'hFC, d, r);
    chk(r, 32'h2);
    for (int i = 0; i < 5; i++) begin
      wr(`PWG_MODE_OFS, {24'h0, modes[i]});
      rd(`PWG_MODE_OFS, d, r);
      chk(d[7:0], modes[i]);
    end
    wr(`PWG_MODE_OFS, 32'h0);
    wr(`PWG_CLKCFG_OFS, 32'h0);
    // idle level is low, so inversion shows on each pin separately
    wr(`PWG_INVERT_OFS, 32'h1);
    repeat (3) @(posedge aclk);
    chk({pwm_out[0], pwm_out_n[0]}, 32'h3);
    wr(`PWG_INVERT_OFS, 32'h100);
    repeat (3) @(posedge aclk);
    chk({pwm_out[0], pwm_out_n[0]}, 32'h0);
    wr(`PWG_INVERT_OFS, 32'h0);
    // ch2 full duty, ch3 halted by period zero, ch4 zero duty
    wr(`PWG_TIMING_OFS + 8'h08, {16'd5, 16'd5});
    wr(`PWG_TIMING_OFS + 8'h0C, {16'd0, 16'd3});
    wr(`PWG_TIMING_OFS + 8'h10, {16'd4, 16'd0});
    wr(`PWG_ENABLE_OFS, 32'h1C);
    repeat (20) @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      chk(pwm_out[4:2], 32'h1);
    end
    rd(`PWG_FLAGS_OFS, d, r);
    chk(d & 32'h1FF, 32'h14);
    wr(`PWG_ENABLE_OFS, 32'h0);
    repeat (10) @(posedge aclk);
    rd(`PWG_FLAGS_OFS, d, r);
    chk(d & 32'h1FF, 32'h14);
    wr(`PWG_FLAGS_OFS, 32'h1FF);
    rd(`PWG_FLAGS_OFS, d, r);
    chk(d & 32'h1FF, 32'h0);
    // counting mode: two frames of ten ticks, three lit
    wr(`PWG_TIMING_OFS, {16'd10, 16'd3});
    wr(`PWG_MODE_OFS, 32'h1);
    wr(`PWG_GROUP_OFS, 32'h2);
    clr <= 1'b0;
    wr(`PWG_ENABLE_OFS, 32'h1);
    wait_flag(`PWG_FLAG_GROUP);
    repeat (30) @(posedge aclk);
    chk(hi, 32'd6);
    chk(ed, 32'd2);
    wr(`PWG_ENABLE_OFS, 32'h0);
    wr(`PWG_FLAGS_OFS, 32'h1FF);
    // dma segments: main lit x2, dark x1, alternate (period 6, 2 lit) x3
    wr(`PWG_MODE_OFS, 32'hF);
    wr(`PWG_ALT_OFS, {16'd5, 16'd2});
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    wr(`PWG_ENABLE_OFS, 32'h1);
    dma_put(16'h8002, 1'b0);
    dma_put(16'h0001, 1'b0);
    dma_put(16'hC003, 1'b1);
    wait_flag(`PWG_FLAG_DMADONE);
    repeat (20) @(posedge aclk);
    chk(hi, 32'd12);
    chk(ed, 32'd5);
    chk(bad, 32'd0);
    wr(`PWG_ENABLE_OFS, 32'h0);
    // software queue: level flag while depth stays below two
    wr(`PWG_MODE_OFS, 32'h7);
    wr(`PWG_TRIG_OFS, 32'h2);
    wr(`PWG_FLAGS_OFS, 32'h1FF);
    rd(`PWG_FLAGS_OFS, d, r);
    chk(d[`PWG_FLAG_QLOW], 32'h1);
    wr(`PWG_QUEUE_OFS, 32'h8001);
    wr(`PWG_QUEUE_OFS, 32'h8001);
    wr(`PWG_FLAGS_OFS, 32'h80);
    rd(`PWG_FLAGS_OFS, d, r);
    chk(d[`PWG_FLAG_QLOW], 32'h0);
    summarize();
  end
endmodule // pwg_top_bench
bind pwg_top pwg_properties #(.NCH(NCH)) i_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .dma_ready(dma_ready),
  .pwm_out(pwm_out), .pwm_out_n(pwm_out_n));
